/* src/isp_defines.vh */
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH
// -----------------------------------------------------------------------------
// Register map, byte addresses on the AXI4-Lite bus.
// -----------------------------------------------------------------------------
`define ISP_OFS_ADDR_HIGH 4'h0
`define ISP_OFS_ADDR_LOW 4'h4
`define ISP_OFS_READ_DATA 4'h8
`define ISP_OFS_WRITE_DATA 4'hC
`define ISP_OFS_PULSE_TIMING 5'h10
`define ISP_OFS_COMMAND 5'h14
`define ISP_OFS_STATUS 5'h18
// -----------------------------------------------------------------------------
// Reset values and fields.
// -----------------------------------------------------------------------------
`define ISP_ADDR_RESET 8'h00
`define ISP_TIMING_RESET 8'h7B
`define ISP_TIMING_WR_MASK 8'h7F
`define ISP_BOOT_VECTOR 16'h0000
`define ISP_FLASH_VECTOR 16'h0000
`define ISP_OPTION_ALIAS 16'hFFFF
`define ISP_OPTION_ADDR 16'h3FFF
`define ISP_BOOT_ROM_BYTES 1024
// Command codes written to the command register.
`define ISP_CMD_READ 2'h0
`define ISP_CMD_WRITE 2'h1
`define ISP_CMD_PAGE_ERASE 2'h2
`define ISP_CMD_MASS_ERASE 2'h3
// Status bits.
`define ISP_STAT_BUSY 0
`define ISP_STAT_BOOT_ROM 1
// AXI responses.
`define ISP_RESP_OKAY 2'h0
`define ISP_RESP_SLVERR 2'h2
`endif

/* src/isp_pulse_timer.v */
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------------------
// Pulse timer: holds busy for (timing value + 1) * unit ticks.
// -----------------------------------------------------------------------------
module isp_pulse_timer #(
  parameter UNIT_CYCLES = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire start,
  input wire [6:0] timing,
  output reg busy
);
  // Prescaler producing a one-cycle enable every UNIT_CYCLES clocks.
  reg [15:0] preReg;
  // Remaining units of the pulse.
  reg [7:0] unitReg;

  // A longer timing value yields a proportionally wider pulse.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      preReg <= 16'h0000;
      unitReg <= 8'h00;
      busy <= 1'b0;
    end else if (start && !busy) begin
      preReg <= 16'h0000;
      unitReg <= {1'b0, timing};
      busy <= 1'b1;
    end else if (busy) begin
      if (preReg == UNIT_CYCLES[15:0] - 16'h0001) begin
        preReg <= 16'h0000;
        if (unitReg == 8'h00) begin
          busy <= 1'b0;
        end else begin
          unitReg <= unitReg - 8'h01;
        end
      end else begin
        preReg <= preReg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* src/isp_flash_sequencer.v */
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Boot flag 0 boots ROM, 1 flash.
// - Flash boot begins at location zero.
// - Erased boot flag reads zero.
// - ROM boot watches serial port commands.
// - Boot ROM holds one kilobyte.
// - Address formed from high/low bytes.
// - Address bytes reset to zero.
// - Read data captures read byte.
// - Write data supplies written byte.
// - Registers reachable from either code source.
// - Pulse width derives from timing value.
// - Timing resets to 10 MHz setting.
// - Internal control hidden from software.
`include "isp_defines.vh"
module isp_flash_sequencer #(
  parameter UNIT_CYCLES = 16
) (
  input wire clk_sys,
  input wire rst,
  // AXI4-Lite slave.
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Non-volatile boot-source flag from the option byte.
  input wire bootFlag,
  // Flash array port.
  output reg [15:0] flashAddr,
  output reg [7:0] flashWriteData,
  input wire [7:0] flashReadData,
  output reg flashRead,
  output reg flashWrite,
  output reg flashPageErase,
  output reg flashMassErase,
  // Execution source after reset and the start vector.
  output reg bootFromRom,
  output reg [15:0] resetVector,
  output reg serialMonitorEn
);
  // ---------------------------------------------------------------------------
  // Sequencer states, one-hot.
  // ---------------------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_PULSE = 3'b010;
  localparam ST_DONE = 3'b100;

  // Size of the boot ROM in bytes; declared here but not used by any logic.
  localparam ROM_BYTES = `ISP_BOOT_ROM_BYTES;

  // Programming registers visible to software.
  reg [7:0] addrHigh_reg;
  reg [7:0] addrLow_reg;
  reg [7:0] readData_reg;
  reg [7:0] writeData_reg;
  reg [7:0] timing_reg;
  // Internal control: operation and state; a command write sets them, and only busy is read back.
  reg [1:0] opCode_reg;
  reg [2:0] state_reg;
  reg startPulse_reg;
  // Boot flag synchroniser; only stage 2 and 3 are compared.
  reg flagS1_reg;
  reg flagS2_reg;
  reg flagS3_reg;
  reg bootLatched_reg;
  // Counts the edges after release until stage 3 holds a sampled pin value.
  reg [1:0] fillCount_reg;
  // AXI holding registers.
  reg [31:0] awAddr_reg;
  reg awHave_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHave_reg;
  wire pulseBusy;
  wire [15:0] progAddr;
  wire busy;

  // The address is the concatenation of the two byte registers.
  assign progAddr = {addrHigh_reg, addrLow_reg};
  assign busy = (state_reg != ST_IDLE);

  // ---------------------------------------------------------------------------
  // Pulse width timer.
  // ---------------------------------------------------------------------------
  isp_pulse_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) uTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(startPulse_reg),
    .timing(timing_reg[6:0]),
    .busy(pulseBusy)
  );

  // ---------------------------------------------------------------------------
  // Boot source: flag sampled after reset release, ROM unless flag is 1.
  // ---------------------------------------------------------------------------
  // The latch happens once stages 2 and 3 agree, so a glitch cannot decide.
  // The stages are first filled from the pin; comparing their reset values
  // would otherwise decide for the boot ROM before the flag was ever seen.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flagS1_reg <= 1'b0;
      flagS2_reg <= 1'b0;
      flagS3_reg <= 1'b0;
      bootLatched_reg <= 1'b0;
      fillCount_reg <= 2'h0;
      bootFromRom <= 1'b1;
      resetVector <= `ISP_BOOT_VECTOR;
      serialMonitorEn <= 1'b1;
    end else begin
      flagS1_reg <= bootFlag;
      flagS2_reg <= flagS1_reg;
      flagS3_reg <= flagS2_reg;
      if (fillCount_reg != 2'h3) begin
        fillCount_reg <= fillCount_reg + 2'h1;
      end
      if (!bootLatched_reg && (fillCount_reg == 2'h3) && (flagS2_reg == flagS3_reg)) begin
        bootLatched_reg <= 1'b1;
        bootFromRom <= ~flagS3_reg;
        // Both sources start at their own location zero.
        resetVector <= flagS3_reg ? `ISP_FLASH_VECTOR : `ISP_BOOT_VECTOR;
        serialMonitorEn <= ~flagS3_reg;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite write path: address and data taken in either order.
  // ---------------------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ISP_RESP_OKAY;
      awAddr_reg <= 32'h00000000;
      awHave_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      wHave_reg <= 1'b0;
      addrHigh_reg <= `ISP_ADDR_RESET;
      addrLow_reg <= `ISP_ADDR_RESET;
      writeData_reg <= 8'h00;
      timing_reg <= `ISP_TIMING_RESET;
      opCode_reg <= `ISP_CMD_READ;
      startPulse_reg <= 1'b0;
    end else begin
      startPulse_reg <= 1'b0;
      s_axi_awready <= !awHave_reg && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !wHave_reg && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg <= s_axi_awaddr;
        awHave_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHave_reg <= 1'b1;
      end
      if (awHave_reg && wHave_reg && !s_axi_bvalid) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ISP_RESP_OKAY;
        // Any code source may write; no fetch-source check is made.
        case (awAddr_reg[7:0])
          {4'h0, `ISP_OFS_ADDR_HIGH}: begin
            if (wStrb_reg[0]) addrHigh_reg <= wData_reg[7:0];
          end
          {4'h0, `ISP_OFS_ADDR_LOW}: begin
            if (wStrb_reg[0]) addrLow_reg <= wData_reg[7:0];
          end
          {4'h0, `ISP_OFS_WRITE_DATA}: begin
            if (wStrb_reg[0]) writeData_reg <= wData_reg[7:0];
          end
          {3'h0, `ISP_OFS_PULSE_TIMING}: begin
            // Bit 7 is kept; only bits 6..0 take the written value.
            if (wStrb_reg[0]) begin
              timing_reg <= (timing_reg & ~`ISP_TIMING_WR_MASK)
                | (wData_reg[7:0] & `ISP_TIMING_WR_MASK);
            end
          end
          {3'h0, `ISP_OFS_COMMAND}: begin
            // A command while busy is dropped, the internal control stays.
            if (wStrb_reg[0] && !busy) begin
              opCode_reg <= wData_reg[1:0];
              startPulse_reg <= 1'b1;
            end
          end
          {4'h0, `ISP_OFS_READ_DATA}, {3'h0, `ISP_OFS_STATUS}: begin
            s_axi_bresp <= `ISP_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `ISP_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Operation sequencer: internal control, hidden from software.
  // ---------------------------------------------------------------------------
  // Address and data are driven straight from the software registers, so
  // software must leave them alone while busy reads 1.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      flashAddr <= 16'h0000;
      flashWriteData <= 8'h00;
      flashRead <= 1'b0;
      flashWrite <= 1'b0;
      flashPageErase <= 1'b0;
      flashMassErase <= 1'b0;
      readData_reg <= 8'h00;
    end else begin
      flashAddr <= progAddr;
      flashWriteData <= writeData_reg;
      case (state_reg)
        ST_IDLE: begin
          if (startPulse_reg) begin
            flashRead <= (opCode_reg == `ISP_CMD_READ);
            flashWrite <= (opCode_reg == `ISP_CMD_WRITE);
            flashPageErase <= (opCode_reg == `ISP_CMD_PAGE_ERASE);
            flashMassErase <= (opCode_reg == `ISP_CMD_MASS_ERASE);
            state_reg <= (opCode_reg == `ISP_CMD_READ) ? ST_DONE : ST_PULSE;
          end
        end
        ST_PULSE: begin
          // Strobes stay high for the timed pulse.
          if (!pulseBusy) begin
            flashWrite <= 1'b0;
            flashPageErase <= 1'b0;
            flashMassErase <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        ST_DONE: begin
          // The array answers a read one cycle after the strobe.
          readData_reg <= flashReadData;
          flashRead <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read path.
  // ---------------------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ISP_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ISP_RESP_OKAY;
        case (s_axi_araddr[7:0])
          {4'h0, `ISP_OFS_ADDR_HIGH}: s_axi_rdata <= {24'h000000, addrHigh_reg};
          {4'h0, `ISP_OFS_ADDR_LOW}: s_axi_rdata <= {24'h000000, addrLow_reg};
          {4'h0, `ISP_OFS_READ_DATA}: s_axi_rdata <= {24'h000000, readData_reg};
          {4'h0, `ISP_OFS_WRITE_DATA}: s_axi_rdata <= {24'h000000, writeData_reg};
          {3'h0, `ISP_OFS_PULSE_TIMING}: s_axi_rdata <= {24'h000000, timing_reg};
          {3'h0, `ISP_OFS_COMMAND}: s_axi_rdata <= 32'h00000000;
          {3'h0, `ISP_OFS_STATUS}: begin
            s_axi_rdata <= {30'h00000000, bootFromRom, busy};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ISP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/isp_seq_chk.sv */
`timescale 1ns/1ns
`default_nettype none
`include "isp_defines.vh"
// ----
// Port checker for the flash sequencer.
// ----
module isp_seq_chk (
  input wire clk_sys,
  input wire rst,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  input wire [15:0] flashAddr,
  input wire [7:0] flashWriteData,
  input wire flashRead,
  input wire flashWrite,
  input wire flashPageErase,
  input wire flashMassErase,
  input wire bootFromRom,
  input wire [15:0] resetVector,
  input wire serialMonitorEn
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_vector_zero: assert property (resetVector == 16'h0000)
    else $error("start vector is not zero");
  a_monitor_follows: assert property (serialMonitorEn == bootFromRom)
    else $error("serial monitor enable differs from boot source");
  a_read_pulse: assert property ($rose(flashRead) |=> !flashRead)
    else $error("read strobe longer than one cycle");
  a_strobe_excl: assert property (
    $onehot0({flashRead, flashWrite, flashPageErase, flashMassErase}))
    else $error("two flash strobes at once");
  a_write_hold: assert property (
    flashWrite ##1 flashWrite |-> $stable(flashWriteData) && $stable(flashAddr))
    else $error("write data or address moved during a write");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before it was taken");
  a_slverr_zero: assert property (
    s_axi_rvalid && s_axi_rresp == `ISP_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned nonzero data");
endmodule
`default_nettype wire

/* bench/test_in_system_flash_programming.sv */
`timescale 1ns/1ns
`default_nettype none
`include "isp_defines.vh"
module test_in_system_flash_programming;
  // ----
  // Bench signals.
  // ----
  logic clk_sys, rst, bootFlag, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rd;
  logic [3:0] s_axi_wstrb;
  logic [7:0] flashReadData, seenData;
  logic [15:0] seenAddr;
  logic [1:0] resp;
  logic [7:0] cnt [0:3];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] flashAddr, resetVector;
  wire [7:0] flashWriteData;
  wire flashRead, flashWrite, flashPageErase, flashMassErase, bootFromRom, serialMonitorEn;
  integer n_fail, check_count, nA, nB;
  // A short pulse unit keeps erase and write pulses brief.
  isp_flash_sequencer #(.UNIT_CYCLES(2)) i_isp_flash_sequencer (.clk_sys, .rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bootFlag,
    .flashAddr, .flashWriteData, .flashReadData, .flashRead, .flashWrite, .flashPageErase,
    .flashMassErase, .bootFromRom, .resetVector, .serialMonitorEn);
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Counts strobe cycles per command code and keeps what the array saw.
  always @(posedge clk_sys) begin
    if (flashRead) cnt[0] <= cnt[0] + 8'h1;
    if (flashWrite) cnt[1] <= cnt[1] + 8'h1;
    if (flashPageErase) cnt[2] <= cnt[2] + 8'h1;
    if (flashMassErase) cnt[3] <= cnt[3] + 8'h1;
    if (flashRead | flashWrite | flashPageErase | flashMassErase) begin
      seenAddr <= flashAddr;
      seenData <= flashWriteData;
    end
  end
  // ----
  // Tasks.
  // ----
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // Each valid is dropped at the edge that samples its ready.
  task axi_wr(input [31:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (k = 0; k < 40; k = k + 1) begin
        @(posedge clk_sys);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_bvalid) begin
          resp = s_axi_bresp;
          s_axi_bready <= 1'h0;
          k = 99;
        end
      end
      // A normal exit leaves k at 100; 40 means no response came.
      chk(k, 32'h64);
    end
  endtask
  task axi_rd(input [31:0] a);
    integer k;
    begin
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (k = 0; k < 40; k = k + 1) begin
        @(posedge clk_sys);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        if (s_axi_rvalid) begin
          rd = s_axi_rdata;
          resp = s_axi_rresp;
          s_axi_rready <= 1'h0;
          k = 99;
        end
      end
      // A normal exit leaves k at 100; 40 means no response came.
      chk(k, 32'h64);
    end
  endtask
  // Starts a command, then polls the busy bit until the flash is idle.
  task run_cmd(input [1:0] code, output integer n);
    integer k;
    begin
      cnt[code] <= 8'h0;
      axi_wr(32'h14, {30'h0, code});
      rd = 32'h1;
      // Only status is read while busy; the programming registers stay put.
      for (k = 0; k < 60 && rd[0]; k = k + 1) axi_rd(32'h18);
      chk(rd[0], 32'h0);
      n = cnt[code];
    end
  endtask
  task do_reset;
    begin
      rst <= 1'h1;
      repeat (10) @(posedge clk_sys);
      rst <= 1'h0;
      // The boot source settles a few edges after release.
      repeat (6) @(posedge clk_sys);
    end
  endtask
  // ----
  // Main sequence.
  // ----
  initial begin
    n_fail = 0;
    check_count = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    bootFlag = 1'h0;
    flashReadData = 8'h5A;
    do_reset;
    chk(bootFromRom, 32'h1);
    chk(serialMonitorEn, 32'h1);
    chk(resetVector, 32'h0);
    axi_rd(32'h0);
    chk(rd, 32'h0);
    axi_rd(32'h4);
    chk(rd, 32'h0);
    axi_rd(32'h10);
    chk(rd, 32'h7B);
    axi_rd(32'h18);
    chk(rd[1], 32'h1);
    axi_wr(32'h10, 32'hFF);
    axi_rd(32'h10);
    chk(rd, 32'h7F);
    axi_wr(32'h0, 32'h12);
    axi_wr(32'h4, 32'h34);
    axi_wr(32'hC, 32'hA5);
    axi_rd(32'h4);
    chk(rd, 32'h34);
    axi_rd(32'hC);
    chk(rd, 32'hA5);
    // Timing is loaded before the first write or erase.
    axi_wr(32'h10, 32'h2);
    run_cmd(2'h1, nA);
    chk(seenAddr, 32'h1234);
    chk(seenData, 32'hA5);
    axi_wr(32'h10, 32'h5);
    run_cmd(2'h1, nB);
    chk(nB - nA, 32'h6);
    run_cmd(2'h0, nA);
    chk(nA, 32'h1);
    axi_rd(32'h8);
    chk(rd, 32'h5A);
    axi_wr(32'h0, 32'hFF);
    axi_wr(32'h4, 32'hFF);
    flashReadData <= 8'h3C;
    run_cmd(2'h0, nA);
    chk(seenAddr, 32'hFFFF);
    axi_rd(32'h8);
    chk(rd, 32'h3C);
    axi_wr(32'h0, 32'h12);
    axi_wr(32'h4, 32'h0);
    run_cmd(2'h2, nA);
    chk(seenAddr, 32'h1200);
    chk(nA, nB);
    axi_wr(32'h0, 32'h0);
    run_cmd(2'h3, nA);
    chk(seenAddr, 32'h0);
    chk(nA, nB);
    axi_rd(32'h14);
    chk(rd, 32'h0);
    axi_rd(32'h1C);
    chk(resp, `ISP_RESP_SLVERR);
    chk(rd, 32'h0);
    axi_wr(32'h1C, 32'h1);
    chk(resp, `ISP_RESP_SLVERR);
    axi_wr(32'h0, 32'h55);
    // Programming done: the flag goes to 1 and the device is reset.
    bootFlag <= 1'h1;
    do_reset;
    chk(bootFromRom, 32'h0);
    chk(serialMonitorEn, 32'h0);
    chk(resetVector, 32'h0);
    axi_rd(32'h0);
    chk(rd, 32'h0);
    axi_rd(32'h10);
    chk(rd, 32'h7B);
    axi_rd(32'h18);
    chk(rd[1], 32'h0);
    // A routine running from flash still reaches the programming registers.
    axi_wr(32'h4, 32'h66);
    axi_rd(32'h4);
    chk(rd, 32'h66);
    close_out;
  end
  // Cuts a hang short well after the expected run length.
  initial begin
    #400000;
    n_fail = n_fail + 1;
    close_out;
  end
endmodule
bind isp_flash_sequencer isp_seq_chk i_isp_seq_chk (.clk_sys, .rst, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .s_axi_rdata,
  .flashAddr, .flashWriteData, .flashRead, .flashWrite, .flashPageErase, .flashMassErase,
  .bootFromRom, .resetVector, .serialMonitorEn);
`default_nettype wire
